// ### common/tape_seq_pkg.sv
// Package of constants and types for the tape block sequencer
package tape_seq_pkg;

  // ------------------------------------------------------------
  // Function codes
  // ------------------------------------------------------------
  localparam logic [2:0] FN_READ_DATA = 3'h2;
  localparam logic [2:0] FN_READ_ALL = 3'h3;
  localparam logic [2:0] FN_WRITE_DATA = 3'h4;
  localparam logic [2:0] FN_WRITE_ALL = 3'h5;

  // ------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_XFER = 4'h8;
  localparam int FN_LSB = 9;
  localparam int CONT_BIT = 12;
  localparam int STATE_LSB = 8;
  localparam logic [2:0] CTRL_FN_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [5:0] PARITY_GOOD = 6'h3F;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    idle_state = 6'h01,
    block_mark_state = 6'h02,
    reverse_check_state = 6'h04,
    data_state = 6'h08,
    final_state = 6'h10,
    checksum_state = 6'h20
  } seq_state_t;

  typedef struct packed {
    logic phase1_pulse;
    logic counter_bit0;
    logic counter_bit1;
    logic counter_bit2;
    logic block_mark_decode;
    logic start_block_mark_decode;
    logic end_block_mark_decode;
    logic counter_sync_decode;
    logic up_to_speed;
    logic [2:0] read_bits;
  } tape_in_t;

endpackage

// ### hw/tape_pin_sync.sv
// Two-stage synchroniser for the tape-side inputs
`timescale 1ns/1ps
module tape_pin_sync #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Async in, synced out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad_width
    $error("width must be positive");
  end

  // ------------------------------------------------------------
  // First stage feeds only the second
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ### hw/block_state_ring.sv
// One-hot ring of block states driven by mark decodes
`timescale 1ns/1ps
module block_state_ring (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Events
  input wire logic up_to_speed,
  input wire logic block_mark,
  input wire logic start_mark,
  input wire logic end_mark,
  input wire logic ck_done,
  // State
  output tape_seq_pkg::seq_state_t state_q,
  output logic ck_exit_q
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= tape_seq_pkg::idle_state;
    end else if (!up_to_speed) begin
      state_q <= tape_seq_pkg::idle_state;
    end else begin
      case (state_q)
        tape_seq_pkg::idle_state: if (block_mark) state_q <= tape_seq_pkg::block_mark_state;
        tape_seq_pkg::block_mark_state: if (start_mark) begin
          state_q <= tape_seq_pkg::reverse_check_state;
        end
        tape_seq_pkg::reverse_check_state: if (start_mark) state_q <= tape_seq_pkg::data_state;
        tape_seq_pkg::data_state: if (end_mark) state_q <= tape_seq_pkg::final_state;
        tape_seq_pkg::final_state: if (end_mark) state_q <= tape_seq_pkg::checksum_state;
        tape_seq_pkg::checksum_state: if (ck_done) state_q <= tape_seq_pkg::idle_state;
        default: state_q <= tape_seq_pkg::idle_state;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ck_exit_q <= 1'b0;
    end else begin
      ck_exit_q <= up_to_speed && ck_done && state_q == tape_seq_pkg::checksum_state;
    end
  end

  property p_idle_forced;
    @(posedge clk) disable iff (!nrst)
      !up_to_speed |=> state_q == tape_seq_pkg::idle_state;
  endproperty
  a_idle_forced: assert property (p_idle_forced) else $error("ring not idle");
endmodule

// ### hw/tape_block_read_write_sequencer.sv
// Read/write sequencer for block-formatted tape with AXI4-Lite control
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module tape_block_read_write_sequencer #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Tape side
  input wire tape_seq_pkg::tape_in_t tape_in,
  output logic [2:0] write_bits,
  output logic write_enable_flop,
  // Data-break channel
  output logic data_flag,
  input wire logic break_grant,
  input wire logic word_count_overflow_pulse,
  input wire logic [17:0] break_data_in,
  output logic [17:0] break_data_out
);
  if (ADDR_W < 4) begin : g_bad_addr
    $error("address width too small for map");
  end

  // ------------------------------------------------------------
  // Input sync and edges
  // ------------------------------------------------------------
  tape_seq_pkg::tape_in_t t;
  tape_seq_pkg::tape_in_t t_p;
  tape_seq_pkg::seq_state_t st_q;
  logic ck_exit;

  tape_pin_sync #(.W($bits(tape_seq_pkg::tape_in_t))) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d(tape_in),
    .q(t)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      t_p <= '0;
    end else begin
      t_p <= t;
    end
  end

  logic ph1, c0_rise, c0_fall, c2_rise, c2_fall, c1_rise;
  logic sm, em, bm, cs;
  assign ph1 = t.phase1_pulse & ~t_p.phase1_pulse;
  assign c0_rise = t.counter_bit0 & ~t_p.counter_bit0;
  assign c0_fall = ~t.counter_bit0 & t_p.counter_bit0;
  assign c2_rise = t.counter_bit2 & ~t_p.counter_bit2;
  assign c2_fall = ~t.counter_bit2 & t_p.counter_bit2;
  assign c1_rise = t.counter_bit1 & ~t_p.counter_bit1;
  assign sm = t.start_block_mark_decode & ~t_p.start_block_mark_decode;
  assign em = t.end_block_mark_decode & ~t_p.end_block_mark_decode;
  assign bm = t.block_mark_decode & ~t_p.block_mark_decode;
  assign cs = t.counter_sync_decode & ~t_p.counter_sync_decode;

  block_state_ring u_ring (
    .clk(clk),
    .nrst(nrst),
    .up_to_speed(t.up_to_speed),
    .block_mark(bm),
    .start_mark(sm),
    .end_mark(em),
    .ck_done(c1_rise),
    .state_q(st_q),
    .ck_exit_q(ck_exit)
  );

  // ------------------------------------------------------------
  // Flops and decodes
  // ------------------------------------------------------------
  logic [2:0] fn_q;
  logic cont_q, all_p_q, sync_q, wcp_q, ovf_q, winh_q, skip_q, eop_q, par_q;
  logic [5:0] rwb_q, lpb_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_ok_q, w_ok_q, wr_fire, ctrl_wr;
  logic rd_data, rd_all, wr_data, wr_all, rev_st, dat_st;
  logic rot, xor_ev, clr_dtb, load_par, go_all, df_set, rall_set, write_enable_flop_d;

  assign rd_data = fn_q == tape_seq_pkg::FN_READ_DATA;
  assign rd_all = fn_q == tape_seq_pkg::FN_READ_ALL;
  assign wr_data = fn_q == tape_seq_pkg::FN_WRITE_DATA;
  assign wr_all = fn_q == tape_seq_pkg::FN_WRITE_ALL;
  assign rev_st = st_q == tape_seq_pkg::reverse_check_state;
  assign dat_st = st_q == tape_seq_pkg::data_state;

  // Gate and inhibit both act before the flop, so outputs stay registered
  assign write_enable_flop_d = sync_q & ~winh_q & ~eop_q
    & ((wr_data & (rev_st | dat_st)) | wr_all);
  assign rot = c2_fall & ((rd_data & dat_st) | (rd_all & sync_q) | write_enable_flop);
  assign xor_ev = rot | (rev_st & c2_fall & (rd_data | wr_data));
  assign go_all = wr_all & sync_q & c0_rise & winh_q & wcp_q & ~skip_q;
  assign clr_dtb = (wr_data & sync_q & rev_st & c0_rise)
    | go_all | (write_enable_flop & c0_rise & (dat_st | wr_all));
  assign load_par = wr_data & st_q == tape_seq_pkg::final_state & em;
  assign rall_set = rd_all & sync_q & c0_fall & wcp_q & ~eop_q;
  assign df_set = (rd_data & dat_st & c2_fall & wcp_q)
    | rall_set | (clr_dtb & wcp_q);
  assign ctrl_wr = wr_fire & awaddr_q[3:0] == tape_seq_pkg::ADDR_CTRL & wstrb_q[1];

  // ------------------------------------------------------------
  // Function register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fn_q <= tape_seq_pkg::CTRL_FN_RESET;
      cont_q <= 1'b0;
    end else if (ctrl_wr) begin
      fn_q <= wdata_q[tape_seq_pkg::FN_LSB +: 3];
      cont_q <= wdata_q[tape_seq_pkg::CONT_BIT];
    end
  end

  // ------------------------------------------------------------
  // Sync lock, word count, overflow in block
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_q <= 1'b0;
    end else if (!t.up_to_speed) begin
      sync_q <= 1'b0;
    end else if (cs) begin
      sync_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wcp_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        wcp_q <= 1'b1;
      end else if (word_count_overflow_pulse) begin
        wcp_q <= 1'b0;
      end
      if (word_count_overflow_pulse) begin
        ovf_q <= 1'b1;
      end else if (ck_exit) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Write inhibit and late-selection skip
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      all_p_q <= 1'b0;
      winh_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      all_p_q <= wr_all;
      if (wr_all & ~all_p_q) begin
        winh_q <= 1'b1;
        skip_q <= ~t.counter_bit2;
      end else if (wr_all & cont_q & word_count_overflow_pulse) begin
        winh_q <= 1'b1;
      end else if (go_all) begin
        winh_q <= 1'b0;
      end else if (c0_rise) begin
        skip_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_enable_flop <= 1'b0;
    end else begin
      write_enable_flop <= write_enable_flop_d;
    end
  end

  // ------------------------------------------------------------
  // Read/write buffer and transfer buffer
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rwb_q <= 6'h00;
    end else if (rot) begin
      rwb_q <= break_data_out[17:12];
    end else if (ph1 & ~write_enable_flop & sync_q & (rd_data | rd_all)) begin
      rwb_q <= {rwb_q[2:0], t.read_bits};
    end else if (ph1 & write_enable_flop) begin
      rwb_q[5:3] <= ~rwb_q[5:3];
    end else if (c2_rise & write_enable_flop) begin
      rwb_q <= {rwb_q[2:0], 3'h0};
    end
  end
  assign write_bits = rwb_q[5:3];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      break_data_out <= 18'h00000;
    end else if (break_grant & data_flag & (wr_data | wr_all)) begin
      break_data_out <= break_data_in;
    end else if (load_par) begin
      break_data_out[5:0] <= lpb_q;
    end else if (clr_dtb) begin
      break_data_out <= 18'h00000;
    end else if (rot) begin
      break_data_out <= {break_data_out[11:0], rwb_q};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lpb_q <= 6'h00;
    end else if (rev_st & ph1 & t.counter_bit2 & (rd_data | wr_data)) begin
      lpb_q <= 6'h00;
    end else if (xor_ev) begin
      lpb_q <= lpb_q ^ rwb_q;
    end
  end

  // ------------------------------------------------------------
  // Flags; a set in the clearing cycle wins
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_flag <= 1'b0;
    end else if (df_set) begin
      data_flag <= 1'b1;
    end else if (break_grant) begin
      data_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eop_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      if (ck_exit & (rd_data | wr_data) & (~cont_q | ovf_q)) begin
        eop_q <= 1'b1;
      end else if ((rd_all & ~cont_q & rall_set)
          | ((rd_all | wr_all) & cont_q & word_count_overflow_pulse)) begin
        eop_q <= 1'b1;
      end else if (ctrl_wr) begin
        eop_q <= 1'b0;
      end
      if (ck_exit & (rd_data | wr_data) & lpb_q != tape_seq_pkg::PARITY_GOOD) begin
        par_q <= 1'b1;
      end else if (ctrl_wr) begin
        par_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  assign wr_fire = aw_ok_q & w_ok_q & ~bvalid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= tape_seq_pkg::RESP_OKAY;
    end else begin
      if (awvalid & awready) begin
        awready <= 1'b0;
        aw_ok_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid & wready) begin
        wready <= 1'b0;
        w_ok_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awaddr_q[3:0] == tape_seq_pkg::ADDR_CTRL) ? tape_seq_pkg::RESP_OKAY
          : tape_seq_pkg::RESP_SLVERR;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= tape_seq_pkg::RESP_OKAY;
    end else if (arvalid & arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= tape_seq_pkg::RESP_OKAY;
      rdata <= 32'h00000000;
      case (araddr[3:0])
        tape_seq_pkg::ADDR_CTRL: begin
          rdata[tape_seq_pkg::FN_LSB +: 3] <= fn_q;
          rdata[tape_seq_pkg::CONT_BIT] <= cont_q;
        end
        tape_seq_pkg::ADDR_STAT: begin
          rdata[6:0] <= {wcp_q, winh_q, write_enable_flop, sync_q, par_q, eop_q, data_flag};
          rdata[tape_seq_pkg::STATE_LSB +: 6] <= st_q;
        end
        tape_seq_pkg::ADDR_XFER: rdata[17:0] <= break_data_out;
        default: rresp <= tape_seq_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid & rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_grant_clears;
    @(posedge clk) disable iff (!nrst)
      break_grant && data_flag && !df_set |=> !data_flag;
  endproperty
  a_grant_clears: assert property (p_grant_clears) else $error("grant left flag");

  property p_read_request;
    @(posedge clk) disable iff (!nrst)
      rd_data && dat_st && c2_fall && wcp_q |=> data_flag;
  endproperty
  a_read_request: assert property (p_read_request) else $error("no read request");

  property p_no_req_after_ovf;
    @(posedge clk) disable iff (!nrst)
      !wcp_q && !data_flag && !clr_dtb |=> !data_flag;
  endproperty
  a_no_req_after_ovf: assert property (p_no_req_after_ovf) else $error("req after ovf");

  property p_parity_error;
    @(posedge clk) disable iff (!nrst)
      ck_exit && rd_data && lpb_q != tape_seq_pkg::PARITY_GOOD |=> par_q;
  endproperty
  a_parity_error: assert property (p_parity_error) else $error("parity not flagged");

  property p_normal_end;
    @(posedge clk) disable iff (!nrst)
      ck_exit && (rd_data || wr_data) && !cont_q |=> eop_q;
  endproperty
  a_normal_end: assert property (p_normal_end) else $error("end flag missing");

  property p_inhibit_blocks;
    @(posedge clk) disable iff (!nrst)
      winh_q ##1 winh_q |-> !write_enable_flop;
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks) else $error("write under inhibit");

  property p_parity_load;
    @(posedge clk) disable iff (!nrst)
      load_par && !(break_grant && data_flag) |=> break_data_out[5:0] == $past(lpb_q);
  endproperty
  a_parity_load: assert property (p_parity_load) else $error("parity not loaded");

  property p_all_start;
    @(posedge clk) disable iff (!nrst)
      go_all && !break_grant |=> !winh_q && data_flag && break_data_out == 18'h00000;
  endproperty
  a_all_start: assert property (p_all_start) else $error("write all no start");
endmodule

// ### testbench/break_channel_model.sv
// Data-break channel model facing the sequencer
`timescale 1ns/1ps
module break_channel_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bench control
  input wire logic [7:0] lag,
  input wire logic ovf_now,
  // Channel
  input wire logic data_flag,
  output logic break_grant,
  output logic word_count_overflow_pulse,
  output logic [17:0] break_data_in
);
  logic [7:0] cnt_q;
  logic ovf_q;
  // ----------------------------------------
  // Grant after a lag, one-cycle pulses
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      ovf_q <= 1'h0;
      break_grant <= 1'h0;
      word_count_overflow_pulse <= 1'h0;
      break_data_in <= 18'h00000;
    end else begin
      break_grant <= 1'h0;
      ovf_q <= ovf_now;
      word_count_overflow_pulse <= ovf_now && !ovf_q;
      // Data lines toggle while idle so stale words never look valid
      break_data_in <= ~break_data_in;
      if (data_flag && !break_grant) begin
        if (cnt_q >= lag) begin
          break_grant <= 1'h1;
          break_data_in <= 18'($urandom);
          cnt_q <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end else begin
        cnt_q <= 8'h00;
      end
    end
  end
endmodule

// ### testbench/tape_block_read_write_sequencer_test.sv
// Self-checking bench for the tape block sequencer
`timescale 1ns/1ps
module tape_block_read_write_sequencer_test;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] r;
  } note_t;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [11:0] tv = 12'h000;
  logic [7:0] lag = 8'h1E;
  logic ovf_now = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, grant, wcop, df;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [17:0] bdi;
  logic [2:0] wb;
  note_t notes[$];
  note_t nt;
  int bad_count = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  // ----------------------------------------
  // Design and channel partner
  // ----------------------------------------
  tape_block_read_write_sequencer u_dut (
    .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .tape_in(tape_seq_pkg::tape_in_t'(tv)), .write_bits(wb), .write_enable_flop(),
    .data_flag(df), .break_grant(grant), .word_count_overflow_pulse(wcop),
    .break_data_in(bdi), .break_data_out()
  );
  break_channel_model u_chan (
    .clk(clk), .nrst(nrst), .lag(lag), .ovf_now(ovf_now), .data_flag(df),
    .break_grant(grant), .word_count_overflow_pulse(wcop), .break_data_in(bdi)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic fail(input string s);
    bad_count++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 50);
    bready <= 1'h0;
    tests_run++;
    if (n >= 50) begin
      fail("write hang");
      complete_run();
    end else if (bresp !== r) begin
      fail("write response");
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    int n;
    n = 0;
    notes.push_back('{d, m, r});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 50);
    rready <= 1'h0;
    if (n >= 50) begin
      fail("read hang");
      complete_run();
    end
  endtask
  task automatic st(input logic [31:0] d, input logic [31:0] m);
    rd(tape_seq_pkg::ADDR_STAT, d, m, tape_seq_pkg::RESP_OKAY);
  endtask
  task automatic ctl(input logic [31:0] d);
    axw(tape_seq_pkg::ADDR_CTRL, d, tape_seq_pkg::RESP_OKAY);
  endtask
  // Levels held well past the two-flop sync
  task automatic pulse(input int b);
    @(posedge clk);
    tv[b] <= 1'h1;
    cyc(4);
    tv[b] <= 1'h0;
    cyc(5);
  endtask
  // Two phase-1 shifts, then counter bit 2 falls
  task automatic slot();
    @(posedge clk);
    tv[8] <= 1'h1;
    pulse(11);
    pulse(11);
    tv[8] <= 1'h0;
    cyc(8);
  endtask
  // Two-cycle level so the partner emits exactly one overflow pulse
  task automatic ovf();
    @(posedge clk);
    ovf_now <= 1'h1;
    cyc(2);
    ovf_now <= 1'h0;
  endtask
  task automatic blk(input int n, input bit pr, input bit ov);
    pulse(7);
    pulse(6);
    slot();
    pulse(6);
    if (ov) ovf();
    for (int i = 0; i < n; i++) begin
      slot();
      if (pr && i == 0) begin
        st(32'h1, 32'h1);
        cyc(40);
        st(32'h0, 32'h1);
      end
      if (ov && i == 0) st(32'h0, 32'h1);
    end
    pulse(5);
    pulse(5);
    pulse(9);
    cyc(8);
  endtask
  // ----------------------------------------
  // Read result checker
  // ----------------------------------------
  always @(posedge clk) begin
    if (rvalid === 1'h1 && rready === 1'h1) begin
      tests_run++;
      if (notes.size() == 0) begin
        fail("unexpected read");
      end else begin
        nt = notes.pop_front();
        if ((rdata & nt.m) !== nt.d || rresp !== nt.r) begin
          $display("BAD %0t read %h want %h", $time, rdata, nt.d);
          bad_count++;
        end
      end
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hFF22FB72));
    cyc(6);
    nrst <= 1'h1;
    tv[3] <= 1'h1;
    tv[2:0] <= 3'h7;
    cyc(4);
    st(32'h100, 32'h3F7F);
    rd(tape_seq_pkg::ADDR_CTRL, 32'h0, 32'h1E00, tape_seq_pkg::RESP_OKAY);
    rd(4'hC, 32'h0, 32'hFFFFFFFF, tape_seq_pkg::RESP_SLVERR);
    axw(tape_seq_pkg::ADDR_STAT, 32'h1, tape_seq_pkg::RESP_SLVERR);
    ctl(32'h800);
    pulse(7);
    pulse(6);
    pulse(10);
    st(32'h0, 32'h9);
    tv[3] <= 1'h0;
    cyc(8);
    st(32'h100, 32'h3F00);
    tv[3] <= 1'h1;
    cyc(4);
    pulse(4);
    st(32'h8, 32'h8);
    pulse(7);
    pulse(6);
    pulse(10);
    st(32'h1, 32'h1);
    slot();
    pulse(6);
    st(32'h810, 32'h3F10);
    cyc(40);
    pulse(5);
    pulse(5);
    pulse(9);
    cyc(8);
    st(32'h102, 32'h3F12);
    ctl(32'h400);
    rd(tape_seq_pkg::ADDR_CTRL, 32'h400, 32'h1E00, tape_seq_pkg::RESP_OKAY);
    blk(2, 1'b1, 1'b0);
    st(32'h102, 32'h3F06);
    lag <= 8'(12 + $urandom_range(0, 8));
    ctl(32'h1400);
    blk(1, 1'b0, 1'b0);
    st(32'h144, 32'h3F46);
    blk(2, 1'b0, 1'b1);
    st(32'h102, 32'h3F02);
    ctl(32'hA00);
    st(32'h20, 32'h20);
    pulse(10);
    st(32'h20, 32'h21);
    pulse(10);
    st(32'h1, 32'h21);
    rd(tape_seq_pkg::ADDR_XFER, 32'h0, 32'h3FFFF, tape_seq_pkg::RESP_OKAY);
    cyc(40);
    ctl(32'h600);
    pulse(11);
    pulse(11);
    tests_run++;
    if (wb !== 3'h7) fail("read all shift");
    slot();
    rd(tape_seq_pkg::ADDR_XFER, 32'h3F, 32'h3F, tape_seq_pkg::RESP_OKAY);
    pulse(10);
    st(32'h3, 32'h3);
    cyc(40);
    ctl(32'h1600);
    ovf();
    st(32'h2, 32'h42);
    complete_run();
  end
endmodule
